//--- design/ief_axil_slave.sv
// axi4-lite slave front end for the interrupt registers
module ief_axil_slave
  import ief_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // register side
  ief_reg_if.slave               regs
);
  typedef enum logic [1:0] {W_IDLE = 2'b01, W_RESP = 2'b10} ief_wst_t;
  typedef enum logic [1:0] {R_IDLE = 2'b01, R_RESP = 2'b10} ief_rst_t;

  ief_wst_t          wst_q;
  ief_rst_t          rst_q;
  logic              aw_q;
  logic              w_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wdata_q;
  logic              wstrb0_q;
  logic              do_wr;

  // address and data may arrive in either order
  assign awready = (wst_q == W_IDLE) && !aw_q;
  assign wready  = (wst_q == W_IDLE) && !w_q;
  assign do_wr   = (wst_q == W_IDLE) && aw_q && w_q;
  assign bvalid  = (wst_q == W_RESP);

  assign regs.wr_en   = do_wr && ief_addr_hit(awaddr_q) && wstrb0_q;
  assign regs.wr_idx  = ief_addr_idx(awaddr_q);
  assign regs.wr_data = wdata_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      aw_q     <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_q     <= 1'b1;
      awaddr_q <= awaddr;
    end else if (bvalid && bready) begin
      aw_q     <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      w_q      <= 1'b0;
      wdata_q  <= '0;
      wstrb0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_q      <= 1'b1;
      wdata_q  <= wdata[7:0];
      wstrb0_q <= wstrb[0];
    end else if (bvalid && bready) begin
      w_q      <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wst_q <= W_IDLE;
      bresp <= RESP_OKAY;
    end else begin
      case (wst_q)
        W_IDLE: begin
          if (do_wr) begin
            wst_q <= W_RESP;
            bresp <= ief_addr_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        W_RESP: begin
          if (bready) begin
            wst_q <= W_IDLE;
          end
        end
        default: wst_q <= W_IDLE;
      endcase
    end
  end

  // read data is captured at the address handshake
  assign arready     = (rst_q == R_IDLE);
  assign rvalid      = (rst_q == R_RESP);
  assign regs.rd_idx = ief_addr_idx(araddr);

  always_ff @(posedge clock) begin
    if (rst) begin
      rst_q <= R_IDLE;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      case (rst_q)
        R_IDLE: begin
          if (arvalid) begin
            rst_q <= R_RESP;
            rdata <= ief_addr_hit(araddr) ? {24'h000000, regs.rd_data} : 32'h00000000;
            rresp <= ief_addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
          end
        end
        R_RESP: begin
          if (rready) begin
            rst_q <= R_IDLE;
          end
        end
        default: rst_q <= R_IDLE;
      endcase
    end
  end
endmodule : ief_axil_slave

//--- design/ief_flag_bits.sv
// sticky request flags with hardware set, hardware clear and software access
module ief_flag_bits
  import ief_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // flag controls
  input  wire logic [NUM_FLG-1:0] set,
  input  wire logic [NUM_FLG-1:0] hw_clr,
  input  wire logic               sw_we,
  input  wire logic [NUM_FLG-1:0] sw_data,
  // state
  output logic      [NUM_FLG-1:0] flags_q
);
  for (genvar i = 0; i < NUM_FLG; i++) begin : g_flag
    // set wins so an event in the clearing cycle is never lost
    always_ff @(posedge clock) begin
      if (rst) begin
        flags_q[i] <= 1'b0;
      end else if (set[i]) begin
        flags_q[i] <= 1'b1;
      end else if (hw_clr[i] || (sw_we && !sw_data[i])) begin
        flags_q[i] <= 1'b0;
      end else if (sw_we) begin
        flags_q[i] <= 1'b1;
      end
    end
  end
endmodule : ief_flag_bits

//--- design/ief_top.sv
// interrupt enable registers, timer 2 and capture/compare flags, request gating
//
// Local design decision: register access over AXI4-Lite.
module ief_top
  import ief_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // timer 2 and capture/compare events
  input  wire logic               t2_reload_evt,
  input  wire logic               t2_overflow_evt,
  input  wire logic [NUM_CCU-1:0] capcmp_evt,
  input  wire logic [NUM_CCU-1:0] isr_enter_capcmp,
  // flags held by other peripherals
  input  wire logic               ext_pin0_flag,
  input  wire logic               timer0_flag,
  input  wire logic               ext_pin1_flag,
  input  wire logic               timer1_flag,
  input  wire logic               uart0_flag,
  input  wire logic               comparator_flag,
  input  wire logic               lowvolt_flag,
  input  wire logic               timebase_flag,
  input  wire logic               adc_flag,
  input  wire logic               twowire_flag,
  // requests to the core
  output logic [NUM_SRC-1:0]      irq_req_q
);
  ief_reg_if rif ();

  logic [7:0]         primary_irq_enable_q;
  logic [7:0]         secondary_irq_enable_q;
  logic [7:0]         lvd_irq_enable_q;
  logic [7:0]         misc_irq_enable_q;
  logic [NUM_FLG-1:0] flags_q;
  logic               flags_we;
  logic [NUM_SRC-1:0] src_flag;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] irq_req_d;
  logic               global_irq_enable;
  logic               t2_reload_irq_enable;
  logic               t2_reload_irq_flag;
  logic               t2_overflow_flag;

  ief_axil_slave u_slave (
    .clock   (clock),
    .rst     (rst),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .regs    (rif.slave)
  );

  // enable registers; unimplemented bits never store
  always_ff @(posedge clock) begin
    if (rst) begin
      primary_irq_enable_q <= REG_RST;
    end else if (rif.wr_en && rif.wr_idx == IDX_PRI_EN) begin
      primary_irq_enable_q <= rif.wr_data & PRI_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      secondary_irq_enable_q <= REG_RST;
    end else if (rif.wr_en && rif.wr_idx == IDX_SEC_EN) begin
      secondary_irq_enable_q <= rif.wr_data & SEC_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lvd_irq_enable_q <= REG_RST;
    end else if (rif.wr_en && rif.wr_idx == IDX_LVD_EN) begin
      lvd_irq_enable_q <= rif.wr_data & LVD_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      misc_irq_enable_q <= REG_RST;
    end else if (rif.wr_en && rif.wr_idx == IDX_MISC_EN) begin
      misc_irq_enable_q <= rif.wr_data & MISC_MASK;
    end
  end

  // flags set on events even while disabled
  assign flags_we = rif.wr_en && rif.wr_idx == IDX_FLAGS;

  ief_flag_bits u_flags (
    .clock   (clock),
    .rst     (rst),
    .set     ({t2_reload_evt, t2_overflow_evt, capcmp_evt}),
    .hw_clr  ({2'h0, isr_enter_capcmp}),
    .sw_we   (flags_we),
    .sw_data (rif.wr_data[7:FLG_LSB]),
    .flags_q (flags_q)
  );

  // read mux; enable reserved bits already stored as zero, flag register bits 1:0 supplied as zero here
  always_comb begin
    case (rif.rd_idx)
      IDX_PRI_EN:  rif.rd_data = primary_irq_enable_q;
      IDX_SEC_EN:  rif.rd_data = secondary_irq_enable_q;
      IDX_LVD_EN:  rif.rd_data = lvd_irq_enable_q;
      IDX_MISC_EN: rif.rd_data = misc_irq_enable_q;
      IDX_FLAGS:   rif.rd_data = {flags_q, 2'h0};
      default:     rif.rd_data = 8'h00;
    endcase
  end

  assign global_irq_enable    = primary_irq_enable_q[PRI_GLOBAL];
  assign t2_reload_irq_enable = secondary_irq_enable_q[SEC_RELOAD];
  assign t2_reload_irq_flag   = flags_q[FLG_RELOAD];
  assign t2_overflow_flag     = flags_q[FLG_T2OVF];

  // source flag and enable vectors
  assign src_flag[SRC_EXT0]  = ext_pin0_flag;
  assign src_flag[SRC_TMR0]  = timer0_flag;
  assign src_flag[SRC_EXT1]  = ext_pin1_flag;
  assign src_flag[SRC_TMR1]  = timer1_flag;
  assign src_flag[SRC_UART0] = uart0_flag;
  // reload only counts when its own enable is set
  assign src_flag[SRC_TMR2]  = t2_overflow_flag ||
                               (t2_reload_irq_flag && t2_reload_irq_enable);
  assign src_flag[SRC_CMP]   = comparator_flag;
  assign src_flag[SRC_LVD]   = lowvolt_flag;
  assign src_flag[SRC_TB]    = timebase_flag;
  assign src_flag[SRC_ADC]   = adc_flag;
  assign src_flag[SRC_TWI]   = twowire_flag;

  assign src_en[SRC_EXT0]  = primary_irq_enable_q[PRI_EXT0];
  assign src_en[SRC_TMR0]  = primary_irq_enable_q[PRI_T0];
  assign src_en[SRC_EXT1]  = primary_irq_enable_q[PRI_EXT1];
  assign src_en[SRC_TMR1]  = primary_irq_enable_q[PRI_T1];
  assign src_en[SRC_UART0] = primary_irq_enable_q[PRI_UART0];
  assign src_en[SRC_TMR2]  = primary_irq_enable_q[PRI_T2];
  assign src_en[SRC_CMP]   = secondary_irq_enable_q[SEC_CMP];
  assign src_en[SRC_LVD]   = lvd_irq_enable_q[LVD_BIT];
  assign src_en[SRC_TB]    = misc_irq_enable_q[MISC_TB];
  assign src_en[SRC_ADC]   = misc_irq_enable_q[MISC_ADC];
  assign src_en[SRC_TWI]   = misc_irq_enable_q[MISC_TWI];

  for (genvar i = 0; i < NUM_CCU; i++) begin : g_ccu
    assign src_flag[SRC_CCU0+i] = flags_q[i];
    assign src_en[SRC_CCU0+i]   = secondary_irq_enable_q[SEC_CCU0+i];
  end

  // one register stage keeps the core's request free of decode glitches
  assign irq_req_d = global_irq_enable ? (src_flag & src_en) : '0;

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_req_q <= '0;
    end else begin
      irq_req_q <= irq_req_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_global_block: assert property (
    !global_irq_enable |=> irq_req_q == '0)
    else $error("request raised while global enable clear");

  chk_event_sets: assert property (
    t2_overflow_evt && !primary_irq_enable_q[PRI_T2] |=> ##0 t2_overflow_flag [*2])
    else $error("overflow event did not set its flag");

  chk_primary_write: assert property (
    rif.wr_en && rif.wr_idx == IDX_PRI_EN
      |=> primary_irq_enable_q == ($past(rif.wr_data) & PRI_MASK))
    else $error("primary enable write not stored");

  chk_sec_reserved: assert property (
    secondary_irq_enable_q[5] == 1'b0 && secondary_irq_enable_q[6] == 1'b0)
    else $error("secondary enable reserved bit set");

  chk_reload_gate: assert property (
    irq_req_q[SRC_TMR2] && !$past(t2_overflow_flag) |-> $past(t2_reload_irq_enable))
    else $error("reload request without reload enable");

  chk_lvd_only: assert property (
    (lvd_irq_enable_q & ~LVD_MASK) == 8'h00)
    else $error("lvd enable holds unimplemented bits");

  chk_misc_mask: assert property (
    (misc_irq_enable_q & ~MISC_MASK) == 8'h00)
    else $error("misc enable holds unimplemented bits");

  chk_flag_layout: assert property (
    rif.rd_idx == IDX_FLAGS |-> rif.rd_data == {t2_reload_irq_flag, t2_overflow_flag,
                                                flags_q[3:0], 2'h0})
    else $error("flag register layout wrong");

  chk_primary_reset: assert property (
    $past(rst) |-> primary_irq_enable_q == REG_RST && irq_req_q == '0)
    else $error("primary enable not zero after reset");

  chk_capcmp_clear: assert property (
    isr_enter_capcmp[0] && !capcmp_evt[0] |=> !flags_q[0])
    else $error("capcmp flag not cleared on service entry");

  chk_overflow_sticky: assert property (
    t2_overflow_flag && !flags_we |=> t2_overflow_flag)
    else $error("overflow flag cleared without software");

  chk_req_cause: assert property (
    irq_req_q[SRC_UART0] |-> $past(uart0_flag) && $past(src_en[SRC_UART0]) &&
                             $past(global_irq_enable))
    else $error("request without flag, enable and global enable");

  chk_ccu_cause: assert property (
    irq_req_q[SRC_CCU0] |-> $past(flags_q[0]) && $past(src_en[SRC_CCU0]))
    else $error("capcmp request without flag and enable");

  cov_ccu_request: cover property (capcmp_evt[2] ##[1:20] irq_req_q[SRC_CCU0+2]);
  cov_reload_request: cover property (t2_reload_evt ##[1:20] irq_req_q[SRC_TMR2]);
  cov_sw_clear: cover property (t2_overflow_flag && flags_we ##1 !t2_overflow_flag);
  cov_set_wins: cover property (capcmp_evt[1] && isr_enter_capcmp[1]);
endmodule : ief_top

//--- shared/ief_pkg.sv
// shared constants for the interrupt enable and flag block
package ief_pkg;
  // bus and register index layout
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned IDX_W       = 8;
  localparam logic [7:0]  IDX_LVD_EN  = 8'h9A;
  localparam logic [7:0]  IDX_PRI_EN  = 8'hA8;
  localparam logic [7:0]  IDX_SEC_EN  = 8'hA9;
  localparam logic [7:0]  IDX_FLAGS   = 8'hC0;
  localparam logic [7:0]  IDX_MISC_EN = 8'hC9;
  localparam logic [7:0]  REG_RST     = 8'h00;
  // implemented bits per register
  localparam logic [7:0]  PRI_MASK    = 8'hBF;
  localparam logic [7:0]  SEC_MASK    = 8'h9F;
  localparam logic [7:0]  LVD_MASK    = 8'h02;
  localparam logic [7:0]  MISC_MASK   = 8'h0E;
  // field positions
  localparam int unsigned PRI_GLOBAL  = 7;
  localparam int unsigned PRI_T2      = 5;
  localparam int unsigned PRI_UART0   = 4;
  localparam int unsigned PRI_T1      = 3;
  localparam int unsigned PRI_EXT1    = 2;
  localparam int unsigned PRI_T0      = 1;
  localparam int unsigned PRI_EXT0    = 0;
  localparam int unsigned SEC_RELOAD  = 7;
  localparam int unsigned SEC_CMP     = 4;
  localparam int unsigned SEC_CCU0    = 0;
  localparam int unsigned LVD_BIT     = 1;
  localparam int unsigned MISC_TB     = 3;
  localparam int unsigned MISC_ADC    = 2;
  localparam int unsigned MISC_TWI    = 1;
  localparam int unsigned FLG_LSB     = 2;
  localparam int unsigned NUM_FLG     = 6;
  localparam int unsigned NUM_CCU     = 4;
  localparam int unsigned FLG_T2OVF   = 4;
  localparam int unsigned FLG_RELOAD  = 5;
  // request vector positions
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_TMR0 = 1;
  localparam int unsigned SRC_EXT1 = 2;
  localparam int unsigned SRC_TMR1 = 3;
  localparam int unsigned SRC_UART0 = 4;
  localparam int unsigned SRC_TMR2 = 5;
  localparam int unsigned SRC_CMP  = 6;
  localparam int unsigned SRC_CCU0 = 7;
  localparam int unsigned SRC_LVD  = 11;
  localparam int unsigned SRC_TB   = 12;
  localparam int unsigned SRC_ADC  = 13;
  localparam int unsigned SRC_TWI  = 14;
  localparam int unsigned NUM_SRC  = 15;
  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  function automatic logic [IDX_W-1:0] ief_addr_idx(input logic [ADDR_W-1:0] a);
    return a[IDX_W+1:2];
  endfunction : ief_addr_idx

  function automatic logic ief_addr_hit(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] i;
    i = ief_addr_idx(a);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:IDX_W+2] == '0) &&
           (i == IDX_LVD_EN || i == IDX_PRI_EN || i == IDX_SEC_EN ||
            i == IDX_FLAGS || i == IDX_MISC_EN);
  endfunction : ief_addr_hit
endpackage : ief_pkg

//--- shared/ief_reg_if.sv
// register access carrier between bus slave and register file
interface ief_reg_if;
  logic       wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  modport slave (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport regs  (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : ief_reg_if

//--- sim/ief_core_model.sv
// core model: takes capcmp requests and signals service routine entry
module ief_core_model
  import ief_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // behaviour controls
  input  wire logic               ack_en,
  input  wire logic [3:0]         ack_delay,
  // requests in, service entry out
  input  wire logic [NUM_SRC-1:0] irq_req_q,
  output logic      [NUM_CCU-1:0] isr_enter_capcmp,
  output logic      [7:0]         ack_cnt_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0]         wait_q;
  logic [1:0]         hold_q;
  logic [NUM_CCU-1:0] pend;
  assign pend = irq_req_q[SRC_CCU0 +: NUM_CCU];
  // lowest unit first; hold off so a served request has dropped before the next look
  always_ff @(posedge clock) begin
    if (rst) begin
      isr_enter_capcmp <= '0;
      wait_q <= '0;
      hold_q <= '0;
      ack_cnt_q <= '0;
    end else begin
      isr_enter_capcmp <= '0;
      if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end else if (ack_en && pend != '0) begin
        if (wait_q < ack_delay) begin
          wait_q <= wait_q + 4'h1;
        end else begin
          wait_q <= '0;
          hold_q <= 2'h3;
          ack_cnt_q <= ack_cnt_q + 8'h01;
          isr_enter_capcmp <= pend & (~pend + 4'h1);
        end
      end
    end
  end
endmodule : ief_core_model

//--- sim/interrupt_enable_flag_logic_test.sv
// self-checking bench for the interrupt enable and flag block
module interrupt_enable_flag_logic_test
  import ief_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clock, rst, awvalid, wvalid, bready, arvalid, rready;
  logic               awready, wready, bvalid, arready, rvalid, t2r, t2o, ack_en;
  logic [ADDR_W-1:0]  awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb, ack_delay;
  logic [1:0]         bresp, rresp;
  logic [NUM_CCU-1:0] ccev, isr;
  logic [9:0]         pf;
  logic [NUM_SRC-1:0] irq;
  logic [7:0]         ack_cnt, s_pri, s_sec, s_lvd, s_misc, s_flg;
  logic [7:0]         ids[5] = '{IDX_LVD_EN, IDX_PRI_EN, IDX_SEC_EN, IDX_FLAGS, IDX_MISC_EN};
  logic [7:0]         msk[5] = '{LVD_MASK, PRI_MASK, SEC_MASK, 8'hFC, MISC_MASK};
  int                 error_cnt, samples_checked, cyc;

  ief_top u_dut (.clock(clock), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .t2_reload_evt(t2r), .t2_overflow_evt(t2o), .capcmp_evt(ccev), .isr_enter_capcmp(isr),
    .ext_pin0_flag(pf[0]), .timer0_flag(pf[1]), .ext_pin1_flag(pf[2]), .timer1_flag(pf[3]),
    .uart0_flag(pf[4]), .comparator_flag(pf[5]), .lowvolt_flag(pf[6]),
    .timebase_flag(pf[7]), .adc_flag(pf[8]), .twowire_flag(pf[9]), .irq_req_q(irq));

  ief_core_model u_core (.clock(clock), .rst(rst), .ack_en(ack_en), .ack_delay(ack_delay),
    .irq_req_q(irq), .isr_enter_capcmp(isr), .ack_cnt_q(ack_cnt));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // a hang counts as a mismatch
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      $display("[ERR] run length expected finish seen hang");
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  function automatic logic [ADDR_W-1:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ra

  // handshakes judged from values settled before the edge that takes them
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                           output logic [1:0] r);
    logic pa, pw, gb, ha, hw, hb;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    gb = 1'b0;
    while (pa || pw || !gb) begin
      @(negedge clock);
      ha = pa && awready;
      hw = pw && wready;
      hb = !gb && bvalid;
      if (hb) r = bresp;
      @(posedge clock);
      if (ha) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (hw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
      if (hb) begin
        bready <= 1'b0;
        gb = 1'b1;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic pa, gr, ha, hr;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    gr = 1'b0;
    while (pa || !gr) begin
      @(negedge clock);
      ha = pa && arready;
      hr = !gr && rvalid;
      if (hr) begin
        d = rdata;
        r = rresp;
      end
      @(posedge clock);
      if (ha) begin
        arvalid <= 1'b0;
        pa = 1'b0;
      end
      if (hr) begin
        rready <= 1'b0;
        gr = 1'b1;
      end
    end
  endtask : axi_read

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    axi_write(ra(idx), d, r);
    chk("bresp", RESP_OKAY, r);
    case (idx)
      IDX_PRI_EN: s_pri = d & PRI_MASK;
      IDX_SEC_EN: s_sec = d & SEC_MASK;
      IDX_LVD_EN: s_lvd = d & LVD_MASK;
      IDX_MISC_EN: s_misc = d & MISC_MASK;
      default: s_flg = d & 8'hFC;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(ra(idx), d, r);
    chk(nm, {24'h000000, exp}, d);
    chk("rresp", RESP_OKAY, r);
  endtask : rd

  function automatic logic [NUM_SRC-1:0] exp_irq();
    logic [NUM_SRC-1:0] e;
    e[SRC_EXT0] = s_pri[PRI_EXT0] & pf[0];
    e[SRC_TMR0] = s_pri[PRI_T0] & pf[1];
    e[SRC_EXT1] = s_pri[PRI_EXT1] & pf[2];
    e[SRC_TMR1] = s_pri[PRI_T1] & pf[3];
    e[SRC_UART0] = s_pri[PRI_UART0] & pf[4];
    e[SRC_TMR2] = s_pri[PRI_T2] & (s_flg[6] | (s_flg[7] & s_sec[SEC_RELOAD]));
    e[SRC_CMP] = s_sec[SEC_CMP] & pf[5];
    for (int i = 0; i < NUM_CCU; i++) e[SRC_CCU0+i] = s_sec[SEC_CCU0+i] & s_flg[FLG_LSB+i];
    e[SRC_LVD] = s_lvd[LVD_BIT] & pf[6];
    e[SRC_TB] = s_misc[MISC_TB] & pf[7];
    e[SRC_ADC] = s_misc[MISC_ADC] & pf[8];
    e[SRC_TWI] = s_misc[MISC_TWI] & pf[9];
    return s_pri[PRI_GLOBAL] ? e : '0;
  endfunction : exp_irq

  // request follows a flag or enable change one edge later; checked after two
  task automatic irq_chk(input string nm);
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(nm, exp_irq(), irq);
  endtask : irq_chk

  task automatic pulse(input logic [5:0] ev);
    @(posedge clock);
    {t2r, t2o, ccev} <= ev;
    @(posedge clock);
    {t2r, t2o, ccev} <= 6'h00;
  endtask : pulse

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++) rd(ids[i], 8'h00, "reset value");
    irq_chk("reset request");
    axi_read(12'h004, d, r);
    chk("unmapped rresp", RESP_SLVERR, r);
    chk("unmapped rdata", 32'h0, d);
    axi_write(12'h2A1, 8'hFF, r);
    chk("misaligned bresp", RESP_SLVERR, r);
    wstrb <= 4'h0;
    axi_write(ra(IDX_PRI_EN), 8'hFF, r);
    chk("masked bresp", RESP_OKAY, r);
    wstrb <= 4'hF;
    rd(IDX_PRI_EN, 8'h00, "after misaligned write");
    $display("test reset done");
  endtask : t_reset

  task automatic t_masks();
    for (int i = 0; i < 5; i++) begin
      wr(ids[i], 8'hFF);
      rd(ids[i], msk[i], "ones readback");
      wr(ids[i], 8'h00);
      rd(ids[i], 8'h00, "zero readback");
    end
    $display("test masks done");
  endtask : t_masks

  task automatic t_gate();
    @(posedge clock);
    pf <= 10'h3FF;
    wr(IDX_FLAGS, 8'hFC);
    wr(IDX_SEC_EN, 8'h9F);
    wr(IDX_LVD_EN, 8'h02);
    wr(IDX_MISC_EN, 8'h0E);
    wr(IDX_PRI_EN, 8'h3F);
    irq_chk("global off");
    chk("global off raw", 32'h0, irq);
    wr(IDX_PRI_EN, 8'hBF);
    irq_chk("all on");
    for (int k = 0; k < 6; k++) begin
      wr(IDX_PRI_EN, 8'h80 | (8'h01 << k));
      irq_chk("single primary enable");
    end
    wr(IDX_PRI_EN, 8'hBF);
    wr(IDX_FLAGS, 8'h00);
    for (int k = 0; k < 10; k++) begin
      @(posedge clock);
      pf <= 10'h001 << k;
      irq_chk("single peripheral flag");
    end
    @(posedge clock);
    pf <= 10'h000;
    for (int i = 0; i < 5; i++) wr(ids[i], 8'h00);
    $display("test gating done");
  endtask : t_gate

  task automatic t_events();
    for (int j = 0; j < 6; j++) begin
      wr(IDX_FLAGS, 8'h00);
      pulse(6'h01 << j);
      rd(IDX_FLAGS, 8'h04 << j, "event flag");
    end
    pulse(6'h3F);
    rd(IDX_FLAGS, 8'hFC, "all event flags");
    s_flg = 8'hFC;
    irq_chk("events with enables off");
    $display("test events done");
  endtask : t_events

  task automatic t_reload();
    wr(IDX_FLAGS, 8'h80);
    wr(IDX_PRI_EN, 8'hA0);
    irq_chk("reload without own enable");
    chk("reload gated", 32'h0, irq[SRC_TMR2]);
    wr(IDX_SEC_EN, 8'h80);
    irq_chk("reload with own enable");
    wr(IDX_FLAGS, 8'h40);
    wr(IDX_SEC_EN, 8'h00);
    irq_chk("overflow request");
    repeat (40) @(posedge clock);
    rd(IDX_FLAGS, 8'h40, "overflow stays");
    wr(IDX_FLAGS, 8'h00);
    irq_chk("overflow cleared by software");
    $display("test reload done");
  endtask : t_reload

  // prompt then slow service entry; capcmp flags clear, overflow does not
  task automatic t_isr();
    int n;
    wr(IDX_SEC_EN, 8'h0F);
    wr(IDX_PRI_EN, 8'hA0);
    for (int p = 0; p < 2; p++) begin
      @(posedge clock);
      ack_delay <= (p == 0) ? 4'h0 : 4'h5;
      ack_en <= 1'b1;
      pulse(6'h1F);
      n = 0;
      while (ack_cnt !== 8'(4 * (p + 1)) && n < 300) begin
        @(negedge clock);
        n++;
      end
      chk("service entries", 4 * (p + 1), ack_cnt);
      rd(IDX_FLAGS, 8'h40, "after service entry");
      s_flg = 8'h40;
      irq_chk("overflow still requests");
      wr(IDX_FLAGS, 8'h00);
    end
    @(posedge clock);
    ack_en <= 1'b0;
    $display("test service entry done");
  endtask : t_isr

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, t2r, t2o, ack_en} = 8'h00;
    awaddr = '0;
    araddr = '0;
    wdata = 32'h0;
    wstrb = 4'hF;
    ccev = '0;
    pf = '0;
    ack_delay = 4'h0;
    {s_pri, s_sec, s_lvd, s_misc, s_flg} = 40'h0;
    error_cnt = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_gate();
    t_events();
    t_reload();
    t_isr();
    results();
  end
endmodule : interrupt_enable_flag_logic_test
